// [verilog/ssa_pkg.sv]
// Constants and types of the subtract, swap and skip datapath
// Operation
// - Skip the next instruction when the tested memory bit is one.
// - Bit test always takes two instruction cycles with a dummy slot.
// - Memory subtract to working: working minus memory into working.
// - Memory subtract to memory: working minus memory into that location.
// - Immediate subtract: working minus constant into working.
// - Borrow-not flag is zero on negative difference, one otherwise.
// - Nibble exchange swaps byte halves in memory, flags unchanged.
package ssa_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int BIT_W = 3;
	localparam int NIB_W = 4;
	localparam logic [7:0] WREG_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam int MSB = 7;

	typedef enum logic [2:0] {
		SSA_OP_NONE,
		SSA_OP_SKIP_BIT,
		SSA_OP_SUB_MEM_W,
		SSA_OP_SUB_MEM_M,
		SSA_OP_SUB_IMM,
		SSA_OP_SWAP
	} ssa_op_e;

	typedef struct packed {
		ssa_op_e op;
		logic [7:0] addr;
		logic [2:0] bit_sel;
		logic [7:0] imm;
	} ssa_instr_s;

	typedef struct packed {
		logic borrow_not_flag;
		logic null_result_flag;
		logic signed_range_exceeded_flag;
		logic nibble_borrow_flag;
	} ssa_flags_s;
endpackage : ssa_pkg

// [verilog/ssa_alu.sv]
// Subtract, nibble swap and bit skip execution datapath
`timescale 1ns/1ps
`default_nettype none
module ssa_alu (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic instr_valid_i,
	input wire ssa_pkg::ssa_instr_s instr_i,
	output logic instr_ready_o,
	output logic [7:0] mem_rd_addr_o,
	input wire logic [7:0] mem_rd_data_i,
	output logic mem_wr_en_o,
	output logic [7:0] mem_wr_addr_o,
	output logic [7:0] mem_wr_data_o,
	output logic skip_o,
	output logic dummy_cycle_o,
	output logic [7:0] working_register_o,
	output var ssa_pkg::ssa_flags_s flags_o
);
	// Stage one presents the read address; stage two executes on read data
	typedef enum {SSA_IDLE, SSA_EXEC, SSA_DUMMY} ssa_state_e;

	ssa_state_e state, next_state;
	ssa_pkg::ssa_instr_s held, next_held;
	logic [7:0] wreg, next_wreg;
	ssa_pkg::ssa_flags_s flags, next_flags;
	logic wr_en, next_wr_en;
	logic [7:0] wr_addr, next_wr_addr;
	logic [7:0] wr_data, next_wr_data;
	logic skip, next_skip;
	logic [7:0] operand;
	logic [8:0] diff9;
	logic [4:0] nib5;
	logic [7:0] diff;

	assign instr_ready_o = (state == SSA_IDLE);
	assign mem_rd_addr_o = (state == SSA_IDLE) ? instr_i.addr : held.addr;

	always_comb begin
		operand = (held.op == ssa_pkg::SSA_OP_SUB_IMM) ? held.imm
			: mem_rd_data_i;
		diff9 = {1'b0, wreg} - {1'b0, operand};
		nib5 = {1'b0, wreg[3:0]} - {1'b0, operand[3:0]};
		diff = diff9[7:0];
	end

	always_comb begin
		next_state = state;
		next_held = held;
		next_wreg = wreg;
		next_flags = flags;
		next_wr_en = 1'b0;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_skip = 1'b0;
		case (state)
			SSA_IDLE: begin
				if (instr_valid_i && instr_i.op != ssa_pkg::SSA_OP_NONE) begin
					next_held = instr_i;
					next_state = SSA_EXEC;
				end
			end
			SSA_EXEC: begin
				next_state = SSA_IDLE;
				case (held.op)
					ssa_pkg::SSA_OP_SKIP_BIT: begin
						next_skip = mem_rd_data_i[held.bit_sel];
						next_state = SSA_DUMMY;
					end
					ssa_pkg::SSA_OP_SUB_MEM_W,
					ssa_pkg::SSA_OP_SUB_IMM,
					ssa_pkg::SSA_OP_SUB_MEM_M: begin
						if (held.op == ssa_pkg::SSA_OP_SUB_MEM_M) begin
							next_wr_en = 1'b1;
							next_wr_addr = held.addr;
							next_wr_data = diff;
						end else begin
							next_wreg = diff;
						end
						next_flags.borrow_not_flag = ~diff9[8];
						next_flags.null_result_flag =
							(diff == ssa_pkg::ZERO_BYTE);
						next_flags.signed_range_exceeded_flag =
							(wreg[ssa_pkg::MSB] != operand[ssa_pkg::MSB]) &&
							(diff[ssa_pkg::MSB] != wreg[ssa_pkg::MSB]);
						next_flags.nibble_borrow_flag = ~nib5[4];
					end
					ssa_pkg::SSA_OP_SWAP: begin
						next_wr_en = 1'b1;
						next_wr_addr = held.addr;
						next_wr_data = {mem_rd_data_i[3:0],
							mem_rd_data_i[7:4]};
					end
					default: begin
					end
				endcase
			end
			SSA_DUMMY: begin
				next_state = SSA_IDLE;
			end
			default: next_state = SSA_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= SSA_IDLE;
			held <= '0;
			wreg <= ssa_pkg::WREG_RESET;
			flags <= ssa_pkg::FLAGS_RESET;
			wr_en <= 1'b0;
			wr_addr <= ssa_pkg::ZERO_BYTE;
			wr_data <= ssa_pkg::ZERO_BYTE;
			skip <= 1'b0;
		end else if (clk_en_i) begin
			state <= next_state;
			held <= next_held;
			wreg <= next_wreg;
			flags <= next_flags;
			wr_en <= next_wr_en;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			skip <= next_skip;
		end
	end

	assign mem_wr_en_o = wr_en && clk_en_i;
	assign mem_wr_addr_o = wr_addr;
	assign mem_wr_data_o = wr_data;
	assign skip_o = skip;
	assign dummy_cycle_o = (state == SSA_DUMMY);
	assign working_register_o = wreg;
	assign flags_o = flags;

	chk_skip_bit_value: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			held.op == ssa_pkg::SSA_OP_SKIP_BIT)
		|=> (skip == $past(mem_rd_data_i[held.bit_sel])))
		else $error("skip does not follow tested bit");

	chk_skip_two_cycles: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			held.op == ssa_pkg::SSA_OP_SKIP_BIT)
		|=> (state == SSA_DUMMY))
		else $error("bit test lacks dummy cycle");

	chk_sub_working: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			held.op == ssa_pkg::SSA_OP_SUB_MEM_W)
		|=> (wreg == $past(wreg) - $past(mem_rd_data_i) && !wr_en))
		else $error("memory subtract to working wrong");

	chk_sub_memory: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			held.op == ssa_pkg::SSA_OP_SUB_MEM_M)
		|=> (wr_en && wr_data == $past(wreg) - $past(mem_rd_data_i)
			&& $stable(wreg)))
		else $error("memory subtract to memory wrong");

	chk_sub_immediate: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			held.op == ssa_pkg::SSA_OP_SUB_IMM)
		|=> (wreg == $past(wreg) - $past(held.imm)))
		else $error("immediate subtract wrong");

	chk_borrow_flag: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC && held.op != ssa_pkg::SSA_OP_SWAP
			&& held.op != ssa_pkg::SSA_OP_SKIP_BIT
			&& held.op != ssa_pkg::SSA_OP_NONE)
		|=> (flags.borrow_not_flag == ($past(wreg) >= $past(operand))))
		else $error("borrow flag wrong");

	chk_swap_nibbles: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC && held.op == ssa_pkg::SSA_OP_SWAP)
		|=> (wr_en && wr_data[3:0] == $past(mem_rd_data_i[7:4])
			&& wr_data[7:4] == $past(mem_rd_data_i[3:0])
			&& $stable(flags)))
		else $error("nibble swap wrong");

	chk_zero_flag: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC && held.op == ssa_pkg::SSA_OP_SUB_IMM)
		|=> (flags.null_result_flag == (wreg == ssa_pkg::ZERO_BYTE)))
		else $error("zero flag wrong");

	// Side effects that instructions must not have, mixed with sequencing and clock enable checks
	chk_skip_no_write: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			held.op == ssa_pkg::SSA_OP_SKIP_BIT)
		|=> (!wr_en && $stable(wreg) && $stable(flags)))
		else $error("bit test changed state");

	chk_skip_single_pulse: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && skip)
		|=> (!skip))
		else $error("skip held too long");

	chk_skip_only_dummy: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(skip)
		|-> (state == SSA_DUMMY))
		else $error("skip outside dummy cycle");

	chk_dummy_to_idle: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_DUMMY)
		|=> (state == SSA_IDLE))
		else $error("dummy cycle not followed by idle");

	chk_exec_after_take: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && instr_ready_o && instr_valid_i &&
			instr_i.op != ssa_pkg::SSA_OP_NONE)
		|=> (state == SSA_EXEC))
		else $error("offered instruction not taken");

	chk_freeze_state: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(!clk_en_i)
		|=> ($stable(state) && $stable(wreg) && $stable(flags)))
		else $error("state moved while clock enable low");

	chk_sub_keeps_memory: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			(held.op == ssa_pkg::SSA_OP_SUB_MEM_W ||
			held.op == ssa_pkg::SSA_OP_SUB_IMM))
		|=> (!wr_en))
		else $error("subtract to working wrote memory");

	chk_write_address: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			(held.op == ssa_pkg::SSA_OP_SUB_MEM_M ||
			held.op == ssa_pkg::SSA_OP_SWAP))
		|=> (wr_en && wr_addr == $past(held.addr)))
		else $error("memory write to wrong address");

	chk_write_single_pulse: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && wr_en)
		|=> (!wr_en))
		else $error("memory write held too long");

	chk_swap_keeps_working: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC && held.op == ssa_pkg::SSA_OP_SWAP)
		|=> ($stable(wreg) && !skip))
		else $error("nibble swap touched working register");

	chk_flags_only_subtract: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state != SSA_EXEC)
		|=> ($stable(flags)))
		else $error("flags moved outside a subtract");

	// Zero flag checks on the forms the check above leaves out, then overflow and nibble checks on all three subtracts
	chk_zero_flag_memory: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			held.op == ssa_pkg::SSA_OP_SUB_MEM_M)
		|=> (flags.null_result_flag == (wr_data == ssa_pkg::ZERO_BYTE)))
		else $error("zero flag wrong on memory result");

	chk_zero_flag_working: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			held.op == ssa_pkg::SSA_OP_SUB_MEM_W)
		|=> (flags.null_result_flag == (wreg == ssa_pkg::ZERO_BYTE)))
		else $error("zero flag wrong on working result");

	chk_overflow_flag: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			(held.op == ssa_pkg::SSA_OP_SUB_MEM_W ||
			held.op == ssa_pkg::SSA_OP_SUB_MEM_M ||
			held.op == ssa_pkg::SSA_OP_SUB_IMM))
		|=> (flags.signed_range_exceeded_flag ==
			((int'($signed($past(wreg))) -
			int'($signed($past(operand)))) > 127 ||
			(int'($signed($past(wreg))) -
			int'($signed($past(operand)))) < -128)))
		else $error("signed overflow flag wrong");

	chk_nibble_flag: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state == SSA_EXEC &&
			(held.op == ssa_pkg::SSA_OP_SUB_MEM_W ||
			held.op == ssa_pkg::SSA_OP_SUB_MEM_M ||
			held.op == ssa_pkg::SSA_OP_SUB_IMM))
		|=> (flags.nibble_borrow_flag ==
			($past(wreg[3:0]) >= $past(operand[3:0]))))
		else $error("nibble borrow flag wrong");
endmodule // ssa_alu
`default_nettype wire

// [verif/ssa_mem_model.sv]
// Data memory model with combinational read and clocked write
`timescale 1ns/1ps
`default_nettype none
module ssa_mem_model (
	input wire logic clk_i,
	input wire logic [7:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_addr_i,
	input wire logic [7:0] wr_data_i
);
	logic [7:0] mem [256];
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'ha5;
	end
	assign rd_data_o = mem[rd_addr_i];
	always @(posedge clk_i) begin
		if (wr_en_i)
			mem[wr_addr_i] <= wr_data_i;
	end
endmodule // ssa_mem_model
`default_nettype wire

// [verif/subtract_swap_skip_alu_test.sv]
// Self-checking bench for the subtract, swap and skip datapath
`timescale 1ns/1ps
`default_nettype none
module subtract_swap_skip_alu_test;
	logic clk = 0, rst = 1, vld = 0, wen, skp, dum, rdy, prdy, pdum;
	logic en = 1;
	ssa_pkg::ssa_instr_s ins = '0;
	ssa_pkg::ssa_flags_s fl, efl = '0;
	logic [7:0] ra, rd, wa, wd, wr, ewr = 8'h00;
	logic [7:0] sh [256];
	logic [29:0] notes [$];
	logic [31:0] lf = 32'he13acd9e;
	int failures = 0, comparisons = 0;
	always #2 clk = ~clk;
	ssa_alu i_ssa_alu (.core_clk_i(clk), .reset_i(rst), .clk_en_i(en),
		.instr_valid_i(vld), .instr_i(ins), .instr_ready_o(rdy),
		.mem_rd_addr_o(ra), .mem_rd_data_i(rd), .mem_wr_en_o(wen),
		.mem_wr_addr_o(wa), .mem_wr_data_o(wd), .skip_o(skp),
		.dummy_cycle_o(dum), .working_register_o(wr), .flags_o(fl));
	ssa_mem_model i_ssa_mem_model (.clk_i(clk), .rd_addr_i(ra),
		.rd_data_o(rd), .wr_en_i(wen), .wr_addr_i(wa), .wr_data_i(wd));
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(logic [29:0] got, logic [29:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Predict the result, note it, then offer the instruction
	task automatic issue(ssa_pkg::ssa_op_e op, logic [31:0] r);
		logic [7:0] ad, im, m, b, d, wdat;
		logic [2:0] bs;
		logic sk, we;
		int n;
		ad = r[7:0];
		bs = r[10:8];
		im = r[23:16];
		m = sh[ad];
		b = (op == ssa_pkg::SSA_OP_SUB_IMM) ? im : m;
		d = ewr - b;
		sk = (op == ssa_pkg::SSA_OP_SKIP_BIT) && m[bs];
		we = op inside {ssa_pkg::SSA_OP_SUB_MEM_M, ssa_pkg::SSA_OP_SWAP};
		wdat = (op == ssa_pkg::SSA_OP_SWAP) ? {m[3:0], m[7:4]} : d;
		if (!we)
			wdat = 8'h00;
		else
			sh[ad] = wdat;
		if (op inside {ssa_pkg::SSA_OP_SUB_MEM_W, ssa_pkg::SSA_OP_SUB_MEM_M,
			ssa_pkg::SSA_OP_SUB_IMM}) begin
			efl = '{ewr >= b, d == 8'h00, (ewr[7] != b[7]) && (d[7] != ewr[7]),
				ewr[3:0] >= b[3:0]};
			if (op != ssa_pkg::SSA_OP_SUB_MEM_M)
				ewr = d;
		end
		notes.push_back({sk, we, we ? ad : 8'h00, wdat, ewr, efl});
		@(posedge clk);
		ins <= '{op, ad, bs, im};
		vld <= 1'b1;
		@(posedge clk);
		vld <= 1'b0;
		#1;
		n = 0;
		while (rdy !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(30'(n), (op == ssa_pkg::SSA_OP_SKIP_BIT) ? 30'h2 : 30'h1);
		if (n >= 8)
			end_of_test();
	endtask
	// Compare each finished operation against the oldest note
	always @(negedge clk) begin
		if (!rst && !prdy && (rdy || dum) && !pdum)
			chk({skp, wen, wen ? wa : 8'h00, wen ? wd : 8'h00, wr, fl},
				notes.pop_front());
		prdy <= rdy;
		pdum <= dum;
	end
	initial begin
		for (int i = 0; i < 256; i++)
			sh[i] = 8'(i) ^ 8'ha5;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		issue(ssa_pkg::SSA_OP_SUB_IMM, 32'h0);
		issue(ssa_pkg::SSA_OP_SUB_IMM, 32'h00800000);
		for (int k = 0; k < 60; k++) begin
			lf = nxt(lf);
			issue(ssa_pkg::ssa_op_e'(lf[26:24] % 3'h5 + 3'h1), lf);
		end
		// An offer while the clock enable is low must not be taken
		@(posedge clk);
		en <= 1'b0;
		ins <= '{ssa_pkg::SSA_OP_SUB_IMM, 8'h00, 3'h0, 8'h5a};
		vld <= 1'b1;
		repeat (3) @(posedge clk);
		vld <= 1'b0;
		en <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk({21'h0, rdy, wr}, {21'h0, 1'b1, ewr});
		repeat (3) @(posedge clk);
		end_of_test();
	end
endmodule // subtract_swap_skip_alu_test
`default_nettype wire
